/* File: inc/gated_counter_params.svh */
// Constants for the gated sixteen bit counter
`ifndef GATED_COUNTER_PARAMS_SVH
`define GATED_COUNTER_PARAMS_SVH
`define CNT_WIDTH 16
`define CNT_RESET 16'h0000
`define PRESCALE_W 2
`define PRESCALE_RESET 2'h0
`define CLK_FREQ_HZ 40000000
`define CRYSTAL_FREQ_HZ 32768
`define CRYSTAL_HALF_CYCLES ((`CLK_FREQ_HZ / `CRYSTAL_FREQ_HZ) / 2)
`define GATE_SRC_W 2
`endif

/* File: inc/gated_counter_pkg.sv */
// Types for the gated sixteen bit counter
package gated_counter_pkg;
    typedef enum logic [1:0] {PS_DIV1, PS_DIV2, PS_DIV4, PS_DIV8} prescale_select_t;
    typedef enum logic [1:0] {SRC_SYSTEM, SRC_EXT_PIN, SRC_CRYSTAL} clk_src_t;
    typedef struct packed {
        logic counterOn;
        logic syncBypass;
        clk_src_t clockSource;
        prescale_select_t prescaleSelect;
    } counter_control_t;
    typedef struct packed {
        logic gateModeEnable;
        logic gatePolarity;
        logic [1:0] gateSource;
    } gate_control_t;
    typedef struct packed {
        logic writeHigh;
        logic writeLow;
        logic [7:0] data;
    } count_write_t;
endpackage

/* File: logic/crystal_osc_32k.sv */
// Model of the 32.768 kHz crystal oscillator as a clock-enable divider
`include "gated_counter_params.svh"
module crystal_osc_32k #(
    parameter int HALF_CYCLES = `CRYSTAL_HALF_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control
    input wire logic crystalOscEnable,
    // Oscillator output level and rising-edge pulse
    output logic crystalLevel_r,
    output logic crystalRise_r
);
    logic [15:0] halfCnt_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            halfCnt_r <= 16'h0000;
            crystalLevel_r <= 1'b0;
            crystalRise_r <= 1'b0;
        end else if (!crystalOscEnable) begin
            halfCnt_r <= 16'h0000;
            crystalLevel_r <= 1'b0;
            crystalRise_r <= 1'b0;
        end else if (halfCnt_r == 16'(HALF_CYCLES - 1)) begin
            halfCnt_r <= 16'h0000;
            crystalLevel_r <= ~crystalLevel_r;
            crystalRise_r <= ~crystalLevel_r;
        end else begin
            halfCnt_r <= halfCnt_r + 16'h0001;
            crystalRise_r <= 1'b0;
        end
    end
endmodule

/* File: logic/gated_sixteen_bit_counter.sv */
// Gated sixteen bit counter with prescaler, crystal source and gate control
// Functional notes
// - The input clock is divided by 1, 2, 4 or 8 according to the prescale select field.
// - The prescale counter is hidden from software and cleared by any write to either count byte.
// - The crystal oscillator runs while its enable bit is set, including during Sleep.
// - With the bypass bit set the resync stage after the prescaler is skipped and counting is asynchronous.
// - In asynchronous mode with an external source the counter runs in Sleep and its overflow can wake.
// - Mode switches may lose or add one increment, which is tolerated.
// - Reading either count byte during asynchronous counting returns a consistent value.
// - The counter counts freely or under gate control with a selectable gate source.
// - Gate mode is enabled by the gate mode bit and its polarity by the polarity bit.
// - With the gate enabling, the counter increments on each prescaler tick, one per 1, 2, 4 or 8 rising source edges.
// - Polarity 1 counts on gate high, polarity 0 counts on gate low, otherwise it holds.
`include "gated_counter_params.svh"
module gated_sixteen_bit_counter
    import gated_counter_pkg::*;
#(
    parameter int CRYSTAL_HALF = `CRYSTAL_HALF_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Configuration
    input wire gated_counter_pkg::counter_control_t counterControl,
    input wire gated_counter_pkg::gate_control_t gateControl,
    input wire logic crystalOscEnable,
    input wire logic sleepMode,
    // Count byte writes
    input wire gated_counter_pkg::count_write_t countWrite,
    // Overflow flag clear
    input wire logic overflowClear,
    // External pins
    input wire logic counterClockPin,
    input wire logic gateInputPin,
    input wire logic [3:1] gateAltSources,
    // Status
    output logic [7:0] countHighByte_r,
    output logic [7:0] countLowByte_r,
    output logic overflowFlag_r,
    output logic wakeRequest_r,
    output logic crystalRunning_r
);
    import gated_counter_pkg::*;

    logic crystalRise;
    logic [2:0] clkPinSync_r;
    logic [1:0] gatePinSync_r;
    logic [3:1] gateAltSync0_r, gateAltSync1_r;
    logic [`PRESCALE_W+1:0] prescale_r;
    logic [`PRESCALE_W+1:0] prescale_nxt;
    logic srcRise;
    logic prescaleTick;
    logic prescaleTickSync_r;
    logic gateLevel;
    logic gateOpen;
    logic countStep;
    logic [`CNT_WIDTH-1:0] count_r;
    logic [`CNT_WIDTH-1:0] count_nxt;
    logic wrap;

    crystal_osc_32k #(.HALF_CYCLES(CRYSTAL_HALF)) crystalOsc (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .crystalOscEnable(crystalOscEnable),
        .crystalLevel_r(),
        .crystalRise_r(crystalRise)
    );

    function automatic logic [3:0] divMask(input prescale_select_t sel);
        case (sel)
            PS_DIV1: divMask = 4'h0;
            PS_DIV2: divMask = 4'h1;
            PS_DIV4: divMask = 4'h3;
            default: divMask = 4'h7;
        endcase
    endfunction

    // Pin synchronisers; third stage only feeds the edge detector
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clkPinSync_r <= 3'h0;
        end else begin
            clkPinSync_r <= {clkPinSync_r[1:0], counterClockPin};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gatePinSync_r <= 2'h0;
            gateAltSync0_r <= 3'h0;
            gateAltSync1_r <= 3'h0;
        end else begin
            gatePinSync_r <= {gatePinSync_r[0], gateInputPin};
            gateAltSync0_r <= gateAltSources;
            gateAltSync1_r <= gateAltSync0_r;
        end
    end

    // Source edge select
    always_comb begin
        case (counterControl.clockSource)
            SRC_SYSTEM: srcRise = 1'b1;
            SRC_EXT_PIN: srcRise = clkPinSync_r[1] & ~clkPinSync_r[2];
            SRC_CRYSTAL: srcRise = crystalRise;
            default: srcRise = 1'b0;
        endcase
    end

    // Prescaler, hidden from software
    always_comb begin
        prescale_nxt = prescale_r + 4'h1;
        prescaleTick = srcRise && ((prescale_r & divMask(counterControl.prescaleSelect)) ==
                                   divMask(counterControl.prescaleSelect));
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prescale_r <= 4'h0;
        end else if (countWrite.writeHigh || countWrite.writeLow) begin
            prescale_r <= 4'h0;
        end else if (prescaleTick) begin
            prescale_r <= 4'h0;
        end else if (srcRise) begin
            prescale_r <= prescale_nxt;
        end
    end

    // Resync stage adds one cycle when bypass is clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prescaleTickSync_r <= 1'b0;
        end else begin
            prescaleTickSync_r <= prescaleTick;
        end
    end

    // Gate source and polarity
    always_comb begin
        case (gateControl.gateSource)
            2'h0: gateLevel = gatePinSync_r[1];
            2'h1: gateLevel = gateAltSync1_r[1];
            2'h2: gateLevel = gateAltSync1_r[2];
            default: gateLevel = gateAltSync1_r[3];
        endcase
        gateOpen = !gateControl.gateModeEnable || (gateLevel == gateControl.gatePolarity);
    end

    // Async mode takes the prescaler tick directly; a mode switch may drop or add one tick
    always_comb begin
        countStep = counterControl.counterOn && gateOpen &&
                    (counterControl.syncBypass ? prescaleTick : prescaleTickSync_r);
        if (!counterControl.syncBypass && sleepMode) begin
            countStep = 1'b0;
        end
        count_nxt = count_r + 16'h0001;
        wrap = countStep && (count_r == 16'hFFFF);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= `CNT_RESET;
        end else if (countWrite.writeHigh) begin
            count_r <= {countWrite.data, count_r[7:0]};
        end else if (countWrite.writeLow) begin
            count_r <= {count_r[15:8], countWrite.data};
        end else if (countStep) begin
            count_r <= count_nxt;
        end
    end

    // Byte views are registered copies, always a settled value
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            countHighByte_r <= 8'h00;
            countLowByte_r <= 8'h00;
        end else begin
            countHighByte_r <= count_r[15:8];
            countLowByte_r <= count_r[7:0];
        end
    end

    // Overflow flag: set wins over clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflowFlag_r <= 1'b0;
        end else if (wrap) begin
            overflowFlag_r <= 1'b1;
        end else if (overflowClear) begin
            overflowFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wakeRequest_r <= 1'b0;
            crystalRunning_r <= 1'b0;
        end else begin
            wakeRequest_r <= sleepMode && wrap;
            crystalRunning_r <= crystalOscEnable;
        end
    end

    a_prescale_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        (countWrite.writeHigh || countWrite.writeLow) |=> prescale_r == 4'h0)
        else $error("prescaler not cleared by count write");
    a_div1_every: assert property (@(posedge ref_clk) disable iff (!resetn)
        (srcRise && counterControl.prescaleSelect == PS_DIV1) |-> prescaleTick)
        else $error("divide by one missed a tick");
    a_div8_spacing: assert property (@(posedge ref_clk) disable iff (!resetn)
        (prescaleTick && counterControl.prescaleSelect == PS_DIV8) |->
        prescale_r[2:0] == 3'h7 ##1 prescale_r == 4'h0)
        else $error("divide by eight tick misplaced");
    a_gate_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        (gateControl.gateModeEnable && gateLevel != gateControl.gatePolarity
         && !countWrite.writeHigh && !countWrite.writeLow) |=> count_r == $past(count_r))
        else $error("count moved with gate closed");
    a_wrap_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        wrap |=> overflowFlag_r && count_r == 16'h0000)
        else $error("wrap did not set overflow");
    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!counterControl.syncBypass && countStep) |-> $past(prescaleTick))
        else $error("sync step without prior tick");
    a_async_direct: assert property (@(posedge ref_clk) disable iff (!resetn)
        (counterControl.syncBypass && counterControl.counterOn && gateOpen && prescaleTick) |-> countStep)
        else $error("async tick not counted");
    a_sleep_run: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sleepMode && wrap) |=> wakeRequest_r ##1 overflowFlag_r)
        else $error("sleep overflow did not wake");
    a_byte_view: assert property (@(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> countLowByte_r == $past(count_r[7:0]) && countHighByte_r == $past(count_r[15:8]))
        else $error("byte view inconsistent");

    c_wrap: cover property (@(posedge ref_clk) disable iff (!resetn) wrap);
    c_gated: cover property (@(posedge ref_clk) disable iff (!resetn)
        gateControl.gateModeEnable && countStep);
    c_sleep_wake: cover property (@(posedge ref_clk) disable iff (!resetn) wakeRequest_r);
    c_crystal_step: cover property (@(posedge ref_clk) disable iff (!resetn)
        counterControl.clockSource == SRC_CRYSTAL && countStep);
endmodule

/* File: sim/tb.sv */
// Self-checking testbench for the gated sixteen bit counter
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gated_counter_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    counter_control_t ctl = '0;
    gate_control_t gc = '0;
    logic crystalOscEnable = 1'b0;
    logic sleepMode = 1'b0;
    count_write_t wcmd = '0;
    logic overflowClear = 1'b0;
    logic counterClockPin = 1'b0;
    logic gateInputPin = 1'b0;
    logic [3:1] gateAltSources = 3'h0;
    logic [7:0] countHighByte_r, countLowByte_r;
    logic overflowFlag_r, wakeRequest_r, crystalRunning_r;
    logic pinRun = 1'b0;
    logic [31:0] seed = 32'd75168;
    logic [15:0] d;
    int error_cnt = 0;
    int compares = 0;
    int wakeCnt = 0;
    gated_sixteen_bit_counter #(.CRYSTAL_HALF(2)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .counterControl(ctl), .gateControl(gc), .crystalOscEnable(crystalOscEnable),
        .sleepMode(sleepMode), .countWrite(wcmd), .overflowClear(overflowClear),
        .counterClockPin(counterClockPin), .gateInputPin(gateInputPin), .gateAltSources(gateAltSources),
        .countHighByte_r(countHighByte_r), .countLowByte_r(countLowByte_r), .overflowFlag_r(overflowFlag_r),
        .wakeRequest_r(wakeRequest_r), .crystalRunning_r(crystalRunning_r));
    always #12.5 ref_clk = ~ref_clk;
    // External pin runs at a quarter of the system clock while enabled
    always @(posedge ref_clk) begin
        if (pinRun) begin
            counterClockPin <= ~counterClockPin;
            @(posedge ref_clk);
        end
    end
    always @(posedge ref_clk) begin
        if (wakeRequest_r === 1'b1) begin
            wakeCnt++;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic setc(input logic on, input logic byp, input clk_src_t s, input prescale_select_t p);
        @(posedge ref_clk);
        ctl <= '{on, byp, s, p};
        repeat (12) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge ref_clk);
        wcmd <= '{1'b1, 1'b0, hi};
        @(posedge ref_clk);
        wcmd <= '{1'b0, 1'b1, lo};
        @(posedge ref_clk);
        wcmd <= '0;
        repeat (4) @(posedge ref_clk);
    endtask
    // Count advance over 64 system cycles
    task automatic meas(output logic [15:0] dd);
        logic [15:0] a;
        @(negedge ref_clk);
        a = {countHighByte_r, countLowByte_r};
        repeat (64) @(negedge ref_clk);
        dd = {countHighByte_r, countLowByte_r} - a;
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        `CHK("reset count", 16'h0000, {countHighByte_r, countLowByte_r})
        `CHK("reset flag", 1'b0, overflowFlag_r)
        // Every divide ratio, with and without synchronisation
        for (int i = 0; i < 8; i++) begin
            setc(1'b1, i[2], SRC_SYSTEM, prescale_select_t'(i[1:0]));
            meas(d);
            `CHK("prescale delta", 16'(64 >> i[1:0]), d)
        end
        // Gate modes, polarities and sources with random gate levels
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            @(posedge ref_clk);
            gc <= '{(i < 8), i[0], i[2:1]};
            gateInputPin <= seed[0];
            gateAltSources <= seed[3:1];
            setc(1'b1, 1'b0, SRC_SYSTEM, PS_DIV1);
            meas(d);
            `CHK("gate delta", ((i >= 8) || (seed[i[2:1]] == i[0])) ? 16'h0040 : 16'h0000, d)
        end
        @(posedge ref_clk);
        gc <= '0;
        // Byte writes with a stopped counter, then wrap
        setc(1'b0, 1'b0, SRC_SYSTEM, PS_DIV1);
        seed = xs(seed);
        wr(seed[15:8], seed[7:0]);
        `CHK("written count", seed[15:0], {countHighByte_r, countLowByte_r})
        wr(8'hFF, 8'hFC);
        setc(1'b1, 1'b0, SRC_SYSTEM, PS_DIV1);
        setc(1'b0, 1'b0, SRC_SYSTEM, PS_DIV1);
        `CHK("overflow flag", 1'b1, overflowFlag_r)
        `CHK("no wake awake", 0, wakeCnt)
        @(posedge ref_clk);
        overflowClear <= 1'b1;
        @(posedge ref_clk);
        overflowClear <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("flag cleared", 1'b0, overflowFlag_r)
        // Sleep: synchronised pin counting stops, asynchronous keeps going and wakes
        for (int k = 0; k < 2; k++) begin
            wr(8'hFF, 8'hF8);
            @(posedge ref_clk);
            sleepMode <= 1'b1;
            setc(1'b1, k[0], SRC_EXT_PIN, PS_DIV1);
            @(posedge ref_clk);
            pinRun <= 1'b1;
            repeat (64) @(posedge ref_clk);
            pinRun <= 1'b0;
            repeat (10) @(posedge ref_clk);
            `CHK("sleep count", k ? 16'h0008 : 16'hFFF8, {countHighByte_r, countLowByte_r})
            `CHK("sleep wake", k, wakeCnt)
            setc(1'b0, 1'b0, SRC_SYSTEM, PS_DIV1);
            sleepMode <= 1'b0;
        end
        // Crystal source with the shortened oscillator period
        @(posedge ref_clk);
        crystalOscEnable <= 1'b1;
        setc(1'b1, 1'b0, SRC_CRYSTAL, PS_DIV1);
        `CHK("crystal running", 1'b1, crystalRunning_r)
        meas(d);
        `CHK("crystal delta", 16'h0010, d)
        // Settling wait: preset FC00, overflow after 1024 crystal clocks
        setc(1'b0, 1'b0, SRC_CRYSTAL, PS_DIV1);
        wr(8'hFC, 8'h00);
        @(posedge ref_clk);
        overflowClear <= 1'b1;
        @(posedge ref_clk);
        overflowClear <= 1'b0;
        setc(1'b1, 1'b0, SRC_CRYSTAL, PS_DIV1);
        repeat (4050) @(posedge ref_clk);
        `CHK("settle early", 1'b0, overflowFlag_r)
        repeat (60) @(posedge ref_clk);
        `CHK("settle flag", 1'b1, overflowFlag_r)
        end_of_test;
    end
endmodule
